// file: rtl/usp_baud.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// oversample tick, bus clock / div
// ****************************************
module usp_baud #(
    parameter int W = 13
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         en,
    input  wire logic [W-1:0] div,
    output logic              tick
);
    logic [W-1:0] cnt;

    // div of zero suppresses the tick; the counter keeps running
    assign tick = en && (div != '0) && (cnt == div - 1'b1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
        end else if (!en || tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: rtl/usp_pkg.sv
// ****************************************
// register map and field layout
// ****************************************
package usp_pkg;
    localparam logic [4:0] OFS_CTRL1 = 5'h00;
    localparam logic [4:0] OFS_CTRL2 = 5'h04;
    localparam logic [4:0] OFS_STAT  = 5'h08;
    localparam logic [4:0] OFS_DATA  = 5'h0c;
    localparam logic [4:0] OFS_BAUD  = 5'h10;
    localparam logic [4:0] OFS_EVT   = 5'h14;
    localparam logic [4:0] OFS_MASK  = 5'h18;

    // control one bit positions
    localparam int unsigned C1_LOOP = 7;
    localparam int unsigned C1_DIR  = 6;
    localparam int unsigned C1_RX_SOURCE_SEL = 5;
    localparam int unsigned C1_NINE = 4;
    localparam int unsigned C1_WAKE = 3;

    // status, event and mask bit positions
    localparam int unsigned ST_TX_EMPTY = 7;
    localparam int unsigned ST_TX_DONE  = 6;
    localparam int unsigned ST_RX_FULL  = 5;
    localparam int unsigned ST_IDLE     = 4;

    localparam logic [7:0]  RST_CTRL1 = 8'h00;
    localparam logic [7:0]  RST_CTRL2 = 8'h00;
    localparam logic [7:0]  RST_MASK  = 8'h00;
    localparam logic [12:0] RST_BAUD  = 13'h0004;

    // timing in oversample ticks and bit times
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] FRAME_8  = 4'ha;
    localparam logic [3:0] FRAME_9  = 4'hb;

    typedef enum logic [1:0] {
        USP_CH_DATA = 2'b00,
        USP_CH_IDLE = 2'b01,
        USP_CH_BRK  = 2'b10
    } usp_kind_t;

    typedef struct packed {
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
        logic idle_line_irq_en;
        logic tx_enable;
        logic rx_enable;
        logic rx_standby_ctl;
        logic send_break_ctl;
    } usp_ctrl2_t;

    typedef struct packed {
        logic tx_out;
        logic tx_oe;
        logic tx_gpio;
        logic rx_gpio;
    } usp_pins_t;
endpackage

// file: rtl/usp_serial.sv
// Overview of operation
// - control two always readable and writable
// - tx enable bit gates empty-flag interrupt
// - rx enable bit gates full-flag interrupt
// - idle enable bit gates idle interrupt
// - transmitter runs and owns pin when enabled
// - internal loopback returns tx pin to port
// - single-wire direction bit steers tx pin
// - enable off-then-on queues one idle character
// - pin held until queued traffic finishes
// - receiver off releases receive pin
// - standby bit waits idle or address mark
// - wake condition clears standby bit itself
// - break bit pulse queues one break
// - held break bit keeps queueing breaks
// - extra break may be queued, timing dependent
// - nine-bit mode widens characters to eleven
// - empty flag set at reset and on load
`timescale 1ns/1ps
`default_nettype none
module usp_serial (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        txd_in,
    input  wire logic        rxd_in,
    output usp_pkg::usp_pins_t pins,
    output logic             irq
);
    // ****************************************
    // registers and state
    // ****************************************
    logic [7:0]          ctrl1;
    usp_pkg::usp_ctrl2_t ctrl2;
    usp_pkg::usp_ctrl2_t wr_c2;
    logic [12:0]         br;
    logic [7:0]          mask;
    logic [7:0]          evt;
    logic [8:0]          txbuf;
    logic                tx_empty;
    logic [8:0]          rxbuf;
    logic                rx_full;
    logic                idle_flag;
    logic                idle_pend;
    logic                brk_pend;
    logic                ack;
    logic                done_q;

    logic loop;
    logic rx_source_sel;
    logic nine;
    logic wake_sel;
    logic tick;
    logic tx_busy;
    logic tx_line;
    logic tx_start;
    logic tx_done;
    logic tx_own;
    logic rx_in;
    usp_pkg::usp_kind_t tx_kind;

    assign loop     = ctrl1[usp_pkg::C1_LOOP];
    assign rx_source_sel     = ctrl1[usp_pkg::C1_RX_SOURCE_SEL];
    assign nine     = ctrl1[usp_pkg::C1_NINE];
    assign wake_sel = ctrl1[usp_pkg::C1_WAKE];
    assign wr_c2    = usp_pkg::usp_ctrl2_t'(avs_writedata[7:0]);

    // ****************************************
    // bus slave, one wait state per access
    // ****************************************
    logic wr_go;
    logic rd_go;
    logic wr_c2_go;
    logic [7:0] stat;
    logic [31:0] rd_mux;

    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_go    = avs_write && ack;
    assign rd_go    = avs_read && ack;
    assign wr_c2_go = wr_go && (avs_address == usp_pkg::OFS_CTRL2);
    assign stat     = {tx_empty, tx_done, rx_full, idle_flag, 4'h0};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    always_comb begin
        unique case (avs_address)
            usp_pkg::OFS_CTRL1: rd_mux = {24'h0, ctrl1};
            usp_pkg::OFS_CTRL2: rd_mux = {24'h0, ctrl2};
            usp_pkg::OFS_STAT:  rd_mux = {24'h0, stat};
            usp_pkg::OFS_DATA:  rd_mux = {23'h0, rxbuf};
            usp_pkg::OFS_BAUD:  rd_mux = {19'h0, br};
            usp_pkg::OFS_EVT:   rd_mux = {24'h0, evt};
            usp_pkg::OFS_MASK:  rd_mux = {24'h0, mask};
            default:            rd_mux = 32'h0;
        endcase
    end

    // read data captured during the wait state, stable at completion
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack) begin
            avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1 <= usp_pkg::RST_CTRL1;
            br    <= usp_pkg::RST_BAUD;
            mask  <= usp_pkg::RST_MASK;
            txbuf <= 9'h000;
        end else if (wr_go) begin
            if (avs_address == usp_pkg::OFS_CTRL1) begin
                ctrl1 <= avs_writedata[7:0];
            end
            if (avs_address == usp_pkg::OFS_BAUD) begin
                br <= avs_writedata[12:0];
            end
            if (avs_address == usp_pkg::OFS_MASK) begin
                mask <= avs_writedata[7:0];
            end
            if (avs_address == usp_pkg::OFS_DATA) begin
                txbuf <= avs_writedata[8:0];
            end
        end
    end

    // ****************************************
    // control two and transmit queueing
    // ****************************************
    logic wake_hit;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl2 <= usp_pkg::usp_ctrl2_t'(usp_pkg::RST_CTRL2);
        end else begin
            if (wake_hit) begin
                ctrl2.rx_standby_ctl <= 1'b0;
            end
            // software write lands last so a set beats the hardware clear
            if (wr_c2_go) begin
                ctrl2 <= wr_c2;
            end
        end
    end

    // a break has priority over a queued idle, data comes last
    always_comb begin
        if (brk_pend || (ctrl2.tx_enable && ctrl2.send_break_ctl)) begin
            tx_kind = usp_pkg::USP_CH_BRK;
        end else if (idle_pend) begin
            tx_kind = usp_pkg::USP_CH_IDLE;
        end else begin
            tx_kind = usp_pkg::USP_CH_DATA;
        end
    end

    assign tx_start = !tx_busy && (brk_pend || idle_pend ||
                      (ctrl2.tx_enable && (ctrl2.send_break_ctl || !tx_empty)));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            brk_pend  <= 1'b0;
            idle_pend <= 1'b0;
        end else begin
            if (tx_start && tx_kind == usp_pkg::USP_CH_BRK) begin
                brk_pend <= 1'b0;
            end
            if (tx_start && tx_kind == usp_pkg::USP_CH_IDLE) begin
                idle_pend <= 1'b0;
            end
            if (wr_c2_go && wr_c2.send_break_ctl && !ctrl2.send_break_ctl) begin
                brk_pend <= 1'b1;
            end
            if (wr_c2_go && wr_c2.tx_enable && !ctrl2.tx_enable) begin
                idle_pend <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_empty <= 1'b1;
        end else if (tx_start && tx_kind == usp_pkg::USP_CH_DATA) begin
            tx_empty <= 1'b1;
        end else if (wr_go && avs_address == usp_pkg::OFS_DATA) begin
            tx_empty <= 1'b0;
        end
    end

    assign tx_done = tx_empty && !tx_busy && !brk_pend && !idle_pend;

    usp_baud #(
        .W (13)
    ) u_baud (
        .clk    (clk),
        .arst_n (arst_n),
        .en     (ctrl2.tx_enable || ctrl2.rx_enable || tx_own),
        .div    (br),
        .tick   (tick)
    );

    usp_tx u_tx (
        .clk      (clk),
        .arst_n   (arst_n),
        .tick     (tick),
        .nine_bit (nine),
        .start    (tx_start),
        .kind     (tx_kind),
        .data     (txbuf),
        .busy     (tx_busy),
        .line     (tx_line)
    );

    // ****************************************
    // pin ownership
    // ****************************************
    assign tx_own       = ctrl2.tx_enable || tx_busy || brk_pend || idle_pend;
    assign pins.tx_out  = tx_line;
    assign pins.tx_gpio = !tx_own || (loop && !rx_source_sel);
    assign pins.tx_oe   = !pins.tx_gpio && (!(loop && rx_source_sel) || ctrl1[usp_pkg::C1_DIR]);
    assign pins.rx_gpio = !ctrl2.rx_enable || loop;

    // single wire hears the shared pin, loopback hears the shifter
    assign rx_in = loop ? (rx_source_sel ? txd_in : tx_line) : rxd_in;

    // ****************************************
    // receiver with standby wakeup
    // ****************************************
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } usp_rx_st_t;

    usp_rx_st_t  rx_st;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_sh;
    logic [7:0]  idle_cnt;
    logic [7:0]  idle_thr;
    logic        idle_armed;
    logic        char_done;
    logic        idle_hit;
    logic        rx_take;

    assign char_done = tick && rx_st == RX_STOP && rx_sub == usp_pkg::OVS_LAST;
    assign idle_thr  = {nine ? usp_pkg::FRAME_9 : usp_pkg::FRAME_8, 4'h0} - 8'h01;
    assign idle_hit  = tick && rx_st == RX_IDLE && rx_in && idle_cnt == idle_thr;
    assign wake_hit  = ctrl2.rx_standby_ctl &&
                       (wake_sel ? (char_done && rx_sh[8]) : idle_hit);
    // the address mark that wakes the receiver is itself received
    assign rx_take   = char_done && (!ctrl2.rx_standby_ctl || wake_hit);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st  <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_bit <= 4'h0;
            rx_sh  <= 9'h000;
        end else if (!ctrl2.rx_enable) begin
            rx_st <= RX_IDLE;
        end else if (tick) begin
            rx_sub <= rx_sub + 4'h1;
            unique case (rx_st)
                RX_IDLE: begin
                    rx_sub <= 4'h0;
                    if (!rx_in) begin
                        rx_st <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_sub == usp_pkg::OVS_MID) begin
                        rx_sub <= 4'h0;
                        rx_bit <= 4'h0;
                        rx_st  <= rx_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sub == usp_pkg::OVS_LAST) begin
                        rx_sh  <= {rx_in, rx_sh[8:1]};
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit == (nine ? 4'h8 : 4'h7)) begin
                            rx_st <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_sub == usp_pkg::OVS_LAST) begin
                        rx_st <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt <= 8'h00;
        end else if (!ctrl2.rx_enable || rx_st != RX_IDLE || !rx_in) begin
            idle_cnt <= 8'h00;
        end else if (tick && idle_cnt != idle_thr) begin
            idle_cnt <= idle_cnt + 8'h01;
        end
    end

    // hardware set beats the data-read clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_full    <= 1'b0;
            idle_flag  <= 1'b0;
            idle_armed <= 1'b0;
            rxbuf      <= 9'h000;
        end else begin
            if (rd_go && avs_address == usp_pkg::OFS_DATA) begin
                rx_full   <= 1'b0;
                idle_flag <= 1'b0;
            end
            if (idle_hit && idle_armed) begin
                idle_armed <= 1'b0;
                idle_flag  <= !ctrl2.rx_standby_ctl;
            end
            if (rx_take) begin
                rx_full    <= 1'b1;
                idle_armed <= 1'b1;
                rxbuf      <= nine ? rx_sh : {1'b0, rx_sh[8:1]};
            end
        end
    end

    // ****************************************
    // events and interrupt
    // ****************************************
    logic [7:0] evt_set;
    logic [7:0] irq_src;

    always_comb begin
        evt_set = 8'h00;
        evt_set[usp_pkg::ST_TX_EMPTY] = tx_start && tx_kind == usp_pkg::USP_CH_DATA;
        evt_set[usp_pkg::ST_TX_DONE]  = tx_done && !done_q;
        evt_set[usp_pkg::ST_RX_FULL]  = rx_take;
        evt_set[usp_pkg::ST_IDLE]     = idle_hit && idle_armed && !ctrl2.rx_standby_ctl;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            evt    <= 8'h00;
            done_q <= 1'b1;
        end else begin
            done_q <= tx_done;
            evt    <= ((rd_go && avs_address == usp_pkg::OFS_EVT) ? 8'h00 : evt) | evt_set;
        end
    end

    assign irq_src = {ctrl2.tx_empty_irq_en && tx_empty,
                      ctrl2.tx_done_irq_en && tx_done,
                      ctrl2.rx_full_irq_en && rx_full,
                      ctrl2.idle_line_irq_en && idle_flag, 4'h0};
    assign irq = (irq_src != 8'h00) || ((evt & mask) != 8'h00);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_tie;
        ctrl2.tx_empty_irq_en && tx_empty |-> irq;
    endproperty
    a_tie: assert property (p_tie) else $error("empty irq missing");
    property p_tx_done_irq_en;
        ctrl2.tx_done_irq_en && tx_done && mask == 8'h00 |-> irq;
    endproperty
    a_tx_done_irq_en: assert property (p_tx_done_irq_en) else $error("done irq missing");
    property p_rie;
        $rose(rx_full) && ctrl2.rx_full_irq_en |-> irq;
    endproperty
    a_rie: assert property (p_rie) else $error("rx irq missing");
    property p_quiet;
        mask == 8'h00 && !(ctrl2.idle_line_irq_en && idle_flag) && !(ctrl2.rx_full_irq_en && rx_full) &&
        !(ctrl2.tx_empty_irq_en && tx_empty) && !(ctrl2.tx_done_irq_en && tx_done) |-> !irq;
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq without enabled flag");
    property p_loop;
        loop && !rx_source_sel |-> pins.tx_gpio && !pins.tx_oe;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback still drives");
    property p_dir;
        loop && rx_source_sel && !ctrl1[usp_pkg::C1_DIR] |-> !pins.tx_oe;
    endproperty
    a_dir: assert property (p_dir) else $error("single wire drives in");
    property p_te_idle;
        wr_c2_go && wr_c2.tx_enable && !ctrl2.tx_enable |=> idle_pend || tx_busy;
    endproperty
    a_te_idle: assert property (p_te_idle) else $error("idle not queued");
    property p_hold;
        !ctrl2.tx_enable && tx_busy && !loop |-> pins.tx_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("pin released early");
    property p_brk;
        tx_start && tx_kind == usp_pkg::USP_CH_BRK |=> tx_busy && !tx_line ##1 !tx_line;
    endproperty
    a_brk: assert property (p_brk) else $error("break not low");
    property p_wake;
        wake_hit && !wr_c2_go |=> !ctrl2.rx_standby_ctl;
    endproperty
    a_wake: assert property (p_wake) else $error("standby not cleared");
    property p_load;
        tx_start && tx_kind == usp_pkg::USP_CH_DATA |=> tx_empty && tx_busy;
    endproperty
    a_load: assert property (p_load) else $error("empty not set on load");

    c_brk:  cover property (tx_start && tx_kind == usp_pkg::USP_CH_BRK);
    c_idle: cover property (tx_start && tx_kind == usp_pkg::USP_CH_IDLE);
    c_rx:   cover property (rx_take);
    c_wake: cover property (wake_hit);
endmodule
`default_nettype wire

// file: rtl/usp_tx.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// character shifter: data, idle or break
// ****************************************
module usp_tx (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              tick,
    input  wire logic              nine_bit,
    input  wire logic              start,
    input  wire usp_pkg::usp_kind_t kind,
    input  wire logic [8:0]        data,
    output logic                   busy,
    output logic                   line
);
    logic [10:0] sh;
    logic [3:0]  sub;
    logic [3:0]  left;

    assign line = busy ? sh[0] : 1'b1;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sh   <= 11'h7ff;
            sub  <= 4'h0;
            left <= 4'h0;
            busy <= 1'b0;
        end else if (start && !busy) begin
            busy <= 1'b1;
            sub  <= 4'h0;
            left <= nine_bit ? usp_pkg::FRAME_9 : usp_pkg::FRAME_8;
            unique case (kind)
                usp_pkg::USP_CH_DATA: begin
                    sh <= nine_bit ? {1'b1, data, 1'b0} : {2'b11, data[7:0], 1'b0};
                end
                usp_pkg::USP_CH_IDLE: sh <= 11'h7ff;
                usp_pkg::USP_CH_BRK:  sh <= 11'h000;
                default:              sh <= 11'h7ff;
            endcase
        end else if (busy && tick) begin
            sub <= sub + 4'h1;
            if (sub == usp_pkg::OVS_LAST) begin
                sh   <= {1'b1, sh[10:1]};
                left <= left - 4'h1;
                if (left == 4'h1) begin
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/usp_remote.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-end transceiver, 16 clocks per bit
// ****************************************
module usp_remote (
    input  wire logic clk,
    input  wire logic line,
    output logic      rxd
);
    // idle line is driven high until the first character
    initial rxd = 1'b1;

    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (15) @(posedge clk);
        end
    endtask

    // sample mid-bit, away from flop updates
    task automatic grab(output logic [9:0] f);
        @(negedge line);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            f[i] = line;
            repeat (16) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// file: verification/usp_serial_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usp_serial_tb;
    logic               clk = 1'b0;
    logic               arst_n = 1'b0;
    logic [4:0]         avs_address = 5'h00;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_writedata = 32'h0;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    wire logic          rxd;
    usp_pkg::usp_pins_t pins;
    logic               irq;
    logic [31:0]        q_exp[$];
    logic [31:0]        q_msk[$];
    logic [31:0]        r;
    logic [9:0]         f;
    logic [7:0]         b;
    logic [7:0]         k;
    int                 seed = 32'h2046;
    int                 n_mismatch = 0;
    int                 tests_run = 0;

    always #5 clk = ~clk;

    usp_serial DUT (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .txd_in(pins.tx_out), .rxd_in(rxd), .pins(pins), .irq(irq));
    usp_remote remote (.clk(clk), .line(pins.tx_out), .rxd(rxd));

    task automatic cmpv(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // bus master and read watcher
    // ****************************************
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        // hold everything until waitrequest is sampled low at a rising edge
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] q);
        q_exp.push_back(e & m);
        q_msk.push_back(m);
        bus(1'b0, a, 32'h0, q);
    endtask

    // a zero mask marks a poll with no expectation
    always @(posedge clk)
        if (avs_read && avs_waitrequest === 1'b0 && q_exp.size() > 0) begin
            if (q_msk[0] != 0) cmpv("readdata", q_exp[0], avs_readdata & q_msk[0]);
            void'(q_exp.pop_front());
            void'(q_msk.pop_front());
        end

    task automatic wait_done;
        for (int n = 0; n < 400; n++) begin
            rd(usp_pkg::OFS_STAT, 32'h0, 32'h0, r);
            if (r[usp_pkg::ST_TX_DONE] === 1'b1) break;
        end
        cmpv("tx_done", 32'h1, {31'h0, r[usp_pkg::ST_TX_DONE]});
    endtask

    initial begin
        #200us;
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(usp_pkg::OFS_CTRL2, {24'h0, usp_pkg::RST_CTRL2}, 32'hff, r);
        b = 8'($random(seed));
        for (int i = 0; i < 4; i++) begin
            k = i ? 8'h80 >> (i - 1) : b & 8'he0;
            wr(usp_pkg::OFS_CTRL2, k);
            rd(usp_pkg::OFS_CTRL2, {24'h0, k}, 32'hff, r);
            cmpv("irq", {31'h0, k[7] | k[6]}, {31'h0, irq});
        end
        wr(usp_pkg::OFS_BAUD, 8'h01);
        wr(usp_pkg::OFS_CTRL1, 8'h80);
        wr(usp_pkg::OFS_CTRL2, 8'h0c);
        @(negedge clk);
        cmpv("gpio", 32'h3, {30'h0, pins.tx_gpio, pins.rx_gpio});
        wr(usp_pkg::OFS_CTRL1, 8'h00);
        @(negedge clk);
        cmpv("pins", 32'h4, {29'h0, pins.tx_oe, pins.tx_gpio, pins.rx_gpio});
        b = 8'($random(seed));
        fork
            remote.grab(f);
            wr(usp_pkg::OFS_DATA, b);
        join
        cmpv("frame", {22'h0, 1'b1, b, 1'b0}, {22'h0, f});
        // drop the enable mid-frame: the pin must stay driven
        b = 8'($random(seed));
        fork
            remote.grab(f);
            begin
                wr(usp_pkg::OFS_DATA, b);
                repeat (40) @(posedge clk);
                wr(usp_pkg::OFS_CTRL2, 8'h04);
                @(negedge clk);
                cmpv("tx_oe", 32'h1, {31'h0, pins.tx_oe});
            end
        join
        cmpv("frame", {22'h0, 1'b1, b, 1'b0}, {22'h0, f});
        wait_done();
        repeat (10) @(negedge clk);
        cmpv("tx_pin", 32'h1, {30'h0, pins.tx_oe, pins.tx_gpio});
        fork
            remote.grab(f);
            begin
                wr(usp_pkg::OFS_CTRL2, 8'h0c);
                wr(usp_pkg::OFS_CTRL2, 8'h0d);
                wr(usp_pkg::OFS_CTRL2, 8'h0c);
            end
        join
        cmpv("break", 32'h0, {22'h0, f});
        wait_done();
        wr(usp_pkg::OFS_CTRL2, 8'h24);
        @(negedge clk);
        cmpv("rx_gpio", 32'h0, {31'h0, pins.rx_gpio});
        remote.send(b);
        repeat (4) @(negedge clk);
        cmpv("irq", 32'h1, {31'h0, irq});
        rd(usp_pkg::OFS_DATA, {24'h0, b}, 32'hff, r);
        wr(usp_pkg::OFS_CTRL1, 8'h08);
        wr(usp_pkg::OFS_CTRL2, 8'h26);
        remote.send(b & 8'h7f);
        rd(usp_pkg::OFS_CTRL2, 32'h26, 32'hff, r);
        remote.send(b | 8'h80);
        repeat (4) @(negedge clk);
        rd(usp_pkg::OFS_CTRL2, 32'h24, 32'hff, r);
        final_report();
    end
endmodule
`default_nettype wire
